//--- hdl/rff_pkg.sv
// Function
// - broadcast enable accepts all broadcast frames
// - multicast enable accepts multicast, broadcast included
// - unicast enable accepts station address matches
// - promiscuous enable passes every destination address
// - inverse filter bit inverts destination check
// - setting run enable starts reception
// - clearing run enable stops after current frame
// - fragment pass skips UDP checksum check
// - fragment pass clear treats fragments normally
// - zero checksum pass lets zero UDP through
// - zero checksum pass clear drops zero UDP
// - UDP-Lite enable (reset set) checks and generates
// - UDP-Lite enable clear skips check and generation
// - ICMP check drops bad non-fragment ICMP
// - source filter drops own-station source frames
// - second control register upper eleven bits read-only
package rff_pkg;

    localparam int RFF_AW = 8;
    localparam int RFF_DW = 16;

    ////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] RFF_OFF_CTRL1 = 8'h74;
    localparam logic [7:0] RFF_OFF_CTRL2 = 8'h76;
    localparam logic [7:0] RFF_OFF_STATUS = 8'h70;
    localparam logic [7:0] RFF_OFF_SA_LOW = 8'h10;
    localparam logic [7:0] RFF_OFF_SA_MID = 8'h12;
    localparam logic [7:0] RFF_OFF_SA_HIGH = 8'h14;

    ////////////////////////////////////////////////////////////////////
    // reset values and writable masks
    localparam logic [15:0] RFF_CTRL1_RST = 16'h0000;
    localparam logic [15:0] RFF_CTRL2_RST = 16'h0004;
    localparam logic [15:0] RFF_SA_RST = 16'h0000;
    localparam logic [15:0] RFF_CTRL1_WMASK = 16'h00ff;
    localparam logic [15:0] RFF_CTRL2_WMASK = 16'h001f;

    ////////////////////////////////////////////////////////////////////
    // first control register fields
    localparam int RFF_BCAST_ACCEPT_EN = 7;
    localparam int RFF_MCAST_ACCEPT_EN = 6;
    localparam int RFF_UCAST_ACCEPT_EN = 5;
    localparam int RFF_PROMISCUOUS_EN = 4;
    localparam int RFF_INVERSE_FILTER_EN = 1;
    localparam int RFF_RECEIVE_RUN_EN = 0;

    // second control register fields
    localparam int RFF_UDP_FRAGMENT_PASS = 4;
    localparam int RFF_UDP_ZERO_CSUM_PASS = 3;
    localparam int RFF_UDP_LITE_CSUM_EN = 2;
    localparam int RFF_ICMP_CSUM_CHECK_EN = 1;
    localparam int RFF_SRC_ADDR_SELF_DROP = 0;

    // status register fields
    localparam int RFF_STAT_RUNNING = 0;
    localparam int RFF_STAT_IN_FRAME = 1;

    ////////////////////////////////////////////////////////////////////
    // frame layout
    localparam logic [3:0] RFF_DST_END = 4'h6;
    localparam logic [3:0] RFF_HDR_BYTES = 4'hc;
    localparam logic [3:0] RFF_IDX_ONE = 4'h1;
    localparam logic [47:0] RFF_BCAST_ADDR = 48'hffff_ffff_ffff;
    localparam int RFF_GROUP_BIT = 40;

    typedef enum logic [1:0] {
        RFF_ST_STOP = 2'b00,
        RFF_ST_RUN = 2'b01,
        RFF_ST_FRAME = 2'b11
    } rff_state_t;

endpackage

//--- hdl/rff_cfg_if.sv
`timescale 1ns/1ps
interface rff_cfg_if;
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [47:0] station;
    logic running;
    logic in_frame;

    modport regs (
        output ctrl1,
        output ctrl2,
        output station,
        input running,
        input in_frame
    );
    modport core (
        input ctrl1,
        input ctrl2,
        input station,
        output running,
        output in_frame
    );
endinterface

//--- hdl/rff_regs.sv
`timescale 1ns/1ps
module rff_regs
    import rff_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [RFF_AW-1:0] addr,
    input wire logic [RFF_DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [RFF_DW-1:0] rdata,
    rff_cfg_if.regs cfg
);

    typedef struct packed {
        logic [15:0] ctrl1;
        logic [15:0] ctrl2;
        logic [15:0] sa_low;
        logic [15:0] sa_mid;
        logic [15:0] sa_high;
        logic [15:0] rdata;
    } rff_regs_t;

    rff_regs_t q, d;

    ////////////////////////////////////////////////////////////////////
    // write and read decode
    always_comb begin
        d = q;
        d.rdata = 16'h0000;
        if (wr) begin
            case (addr)
                RFF_OFF_CTRL1: d.ctrl1 = wdata & RFF_CTRL1_WMASK;
                RFF_OFF_CTRL2: d.ctrl2 = wdata & RFF_CTRL2_WMASK;
                RFF_OFF_SA_LOW: d.sa_low = wdata;
                RFF_OFF_SA_MID: d.sa_mid = wdata;
                RFF_OFF_SA_HIGH: d.sa_high = wdata;
                default: d.ctrl1 = q.ctrl1;
            endcase
        end
        if (rd) begin
            case (addr)
                RFF_OFF_CTRL1: d.rdata = q.ctrl1;
                RFF_OFF_CTRL2: d.rdata = q.ctrl2;
                RFF_OFF_SA_LOW: d.rdata = q.sa_low;
                RFF_OFF_SA_MID: d.rdata = q.sa_mid;
                RFF_OFF_SA_HIGH: d.rdata = q.sa_high;
                RFF_OFF_STATUS: begin
                    d.rdata[RFF_STAT_RUNNING] = cfg.running;
                    d.rdata[RFF_STAT_IN_FRAME] = cfg.in_frame;
                end
                default: d.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q.ctrl1 <= RFF_CTRL1_RST;
            q.ctrl2 <= RFF_CTRL2_RST;
            q.sa_low <= RFF_SA_RST;
            q.sa_mid <= RFF_SA_RST;
            q.sa_high <= RFF_SA_RST;
            q.rdata <= 16'h0000;
        end else if (ce) begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign cfg.ctrl1 = q.ctrl1;
    assign cfg.ctrl2 = q.ctrl2;
    assign cfg.station = {q.sa_high, q.sa_mid, q.sa_low};

endmodule

//--- hdl/rff_filter_top.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module rff_filter_top
    import rff_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [RFF_AW-1:0] reg_addr,
    input wire logic [RFF_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [RFF_DW-1:0] reg_rdata,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic pkt_udp,
    input wire logic pkt_udp_lite,
    input wire logic pkt_icmp,
    input wire logic pkt_frag,
    input wire logic udp_csum_zero,
    input wire logic udp_lite_csum_ok,
    input wire logic icmp_csum_ok,
    output logic frm_accept,
    output logic frm_drop,
    output logic rx_running,
    output logic tx_udp_lite_gen_en
);

    ////////////////////////////////////////////////////////////////////
    // register file
    rff_cfg_if cfg_if ();

    rff_regs u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .addr(reg_addr),
        .wdata(reg_wdata),
        .wr(reg_wr),
        .rd(reg_rd),
        .rdata(reg_rdata),
        .cfg(cfg_if.regs)
    );

    ////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic addr_eq(input logic [47:0] a,
                                     input logic [47:0] b);
        addr_eq = (a == b);
    endfunction

    function automatic logic [47:0] shift_in(input logic [47:0] a,
                                             input logic [7:0] b);
        shift_in = {a[39:0], b};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // control decode
    logic bcast_accept_en;
    logic mcast_accept_en;
    logic ucast_accept_en;
    logic promiscuous_en;
    logic inverse_filter_en;
    logic receive_run_en;
    logic udp_fragment_pass;
    logic udp_zero_csum_pass;
    logic udp_lite_csum_en;
    logic icmp_csum_check_en;
    logic src_addr_self_drop;

    assign bcast_accept_en = cfg_if.ctrl1[RFF_BCAST_ACCEPT_EN];
    assign mcast_accept_en = cfg_if.ctrl1[RFF_MCAST_ACCEPT_EN];
    assign ucast_accept_en = cfg_if.ctrl1[RFF_UCAST_ACCEPT_EN];
    assign promiscuous_en = cfg_if.ctrl1[RFF_PROMISCUOUS_EN];
    assign inverse_filter_en = cfg_if.ctrl1[RFF_INVERSE_FILTER_EN];
    assign receive_run_en = cfg_if.ctrl1[RFF_RECEIVE_RUN_EN];
    assign udp_fragment_pass = cfg_if.ctrl2[RFF_UDP_FRAGMENT_PASS];
    assign udp_zero_csum_pass = cfg_if.ctrl2[RFF_UDP_ZERO_CSUM_PASS];
    assign udp_lite_csum_en = cfg_if.ctrl2[RFF_UDP_LITE_CSUM_EN];
    assign icmp_csum_check_en = cfg_if.ctrl2[RFF_ICMP_CSUM_CHECK_EN];
    assign src_addr_self_drop = cfg_if.ctrl2[RFF_SRC_ADDR_SELF_DROP];

    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        rff_state_t st;
        logic in_pkt;
        logic [3:0] idx;
        logic [47:0] dst;
        logic [47:0] src;
        logic accept;
        logic drop;
        logic running;
        logic lite_gen;
    } rff_core_t;

    rff_core_t q, d;

    ////////////////////////////////////////////////////////////////////
    // destination and checksum decisions
    logic is_bcast;
    logic is_mcast;
    logic ucast_hit;
    logic normal_ok;
    logic dst_ok;
    logic src_hit;
    logic frag_skip;
    logic udp_ok;
    logic lite_ok;
    logic icmp_ok;
    logic csum_ok;
    logic hdr_done;
    logic first_byte;
    logic eop;

    always_comb begin
        is_bcast = addr_eq(q.dst, RFF_BCAST_ADDR);
        is_mcast = q.dst[RFF_GROUP_BIT];
        ucast_hit = !is_mcast && addr_eq(q.dst, cfg_if.station);
        normal_ok = (is_bcast && bcast_accept_en)
                  || (is_mcast && mcast_accept_en)
                  || (ucast_hit && ucast_accept_en);
        if (promiscuous_en) begin
            dst_ok = 1'b1;
        end else if (inverse_filter_en) begin
            dst_ok = !normal_ok;
        end else begin
            dst_ok = normal_ok;
        end
        src_hit = src_addr_self_drop
                && addr_eq(q.src, cfg_if.station);
        frag_skip = pkt_frag && udp_fragment_pass;
        udp_ok = !pkt_udp || frag_skip || !udp_csum_zero
               || udp_zero_csum_pass;
        lite_ok = !pkt_udp_lite || frag_skip || !udp_lite_csum_en
                || udp_lite_csum_ok;
        icmp_ok = !pkt_icmp || pkt_frag || !icmp_csum_check_en
                || icmp_csum_ok;
        csum_ok = udp_ok && lite_ok && icmp_ok;
        hdr_done = (q.idx >= RFF_HDR_BYTES);
        first_byte = rx_valid && !q.in_pkt;
        eop = (q.st == RFF_ST_FRAME) && rx_valid && rx_last;
    end

    ////////////////////////////////////////////////////////////////////
    // receive sequencing
    always_comb begin
        d = q;
        d.accept = 1'b0;
        d.drop = 1'b0;
        if (rx_valid) begin
            d.in_pkt = !rx_last;
        end
        case (q.st)
            RFF_ST_STOP: begin
                if (receive_run_en) begin
                    d.st = RFF_ST_RUN;
                end
            end
            RFF_ST_RUN: begin
                if (!receive_run_en) begin
                    d.st = RFF_ST_STOP;
                end else if (first_byte) begin
                    d.dst = shift_in(q.dst, rx_data);
                    d.idx = RFF_IDX_ONE;
                    if (rx_last) begin
                        d.drop = 1'b1;
                    end else begin
                        d.st = RFF_ST_FRAME;
                    end
                end
            end
            RFF_ST_FRAME: begin
                if (rx_valid) begin
                    if (q.idx < RFF_DST_END) begin
                        d.dst = shift_in(q.dst, rx_data);
                    end else if (!hdr_done) begin
                        d.src = shift_in(q.src, rx_data);
                    end
                    if (!hdr_done) begin
                        d.idx = q.idx + RFF_IDX_ONE;
                    end
                    if (rx_last) begin
                        if (hdr_done && dst_ok && csum_ok && !src_hit) begin
                            d.accept = 1'b1;
                        end else begin
                            d.drop = 1'b1;
                        end
                        if (receive_run_en) begin
                            d.st = RFF_ST_RUN;
                        end else begin
                            d.st = RFF_ST_STOP;
                        end
                    end
                end
            end
            default: d.st = RFF_ST_STOP;
        endcase
        d.running = (d.st != RFF_ST_STOP);
        d.lite_gen = udp_lite_csum_en;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q.st <= RFF_ST_STOP;
            q.in_pkt <= 1'b0;
            q.idx <= 4'h0;
            q.dst <= 48'h0000_0000_0000;
            q.src <= 48'h0000_0000_0000;
            q.accept <= 1'b0;
            q.drop <= 1'b0;
            q.running <= 1'b0;
            q.lite_gen <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    assign frm_accept = q.accept;
    assign frm_drop = q.drop;
    assign rx_running = q.running;
    assign tx_udp_lite_gen_en = q.lite_gen;
    assign cfg_if.running = q.running;
    assign cfg_if.in_frame = (q.st == RFF_ST_FRAME);

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_end;
        ce && eop && hdr_done;
    endsequence

    sequence s_clean_csum;
        csum_ok && !src_hit;
    endsequence

    sequence s_verdict_accept;
        frm_accept && !frm_drop;
    endsequence

    sequence s_verdict_drop;
        frm_drop && !frm_accept;
    endsequence

    AST_BCAST: assert property (
        s_end and (is_bcast && bcast_accept_en && !inverse_filter_en)
        and s_clean_csum |=> s_verdict_accept)
        else $error("broadcast frame not accepted");

    AST_MCAST: assert property (
        s_end and (is_mcast && mcast_accept_en && !inverse_filter_en)
        and s_clean_csum |=> s_verdict_accept)
        else $error("multicast frame not accepted");

    AST_UCAST: assert property (
        s_end and (ucast_hit && ucast_accept_en && !inverse_filter_en)
        and s_clean_csum |=> s_verdict_accept)
        else $error("station unicast frame not accepted");

    AST_PROMISC: assert property (
        s_end and promiscuous_en and s_clean_csum |=> s_verdict_accept)
        else $error("promiscuous frame not accepted");

    AST_INVERSE: assert property (
        s_end and (inverse_filter_en && !promiscuous_en && normal_ok)
        |=> s_verdict_drop)
        else $error("inverse filter passed a matching frame");

    AST_START: assert property (
        ce && q.st == RFF_ST_STOP && receive_run_en
        |=> rx_running ##1 (!ce || rx_running || !receive_run_en))
        else $error("receiver did not start");

    AST_GRACE: assert property (
        ce && q.st == RFF_ST_FRAME && !(rx_valid && rx_last)
        |=> q.st == RFF_ST_FRAME && rx_running)
        else $error("frame aborted before its end");

    AST_STOP: assert property (
        ce && eop && !receive_run_en |=> !rx_running)
        else $error("receiver kept running after frame end");

    AST_ZERO: assert property (
        s_end and (pkt_udp && udp_csum_zero && !udp_zero_csum_pass
        && !frag_skip) |=> s_verdict_drop)
        else $error("zero checksum udp frame not dropped");

    AST_ICMP: assert property (
        s_end and (pkt_icmp && !pkt_frag && icmp_csum_check_en
        && !icmp_csum_ok) |=> s_verdict_drop)
        else $error("bad icmp frame not dropped");

    AST_SELF: assert property (
        s_end and src_hit |=> s_verdict_drop)
        else $error("own source frame not dropped");

    AST_LITE: assert property (
        ce && !udp_lite_csum_en |=> !tx_udp_lite_gen_en)
        else $error("udp-lite generation not disabled");

endmodule

//--- tb/rff_phy_model.sv
`timescale 1ns/1ps
module rff_phy_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [47:0] dst,
    input wire logic [47:0] src,
    input wire logic [3:0] extra,
    input wire logic [6:0] fl,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic [6:0] cls
);
    logic busy_q;
    logic [4:0] idx_q;
    logic [4:0] tot_q;
    logic [7:0] hold_q;
    logic [47:0] dst_q;
    logic [47:0] src_q;
    logic [6:0] fl_q;
    logic [7:0] cur;

    ////////////////////////////////////////////////////////////////////
    // byte order: destination, source, filler
    always_comb begin
        if (idx_q < 5'd6) begin
            cur = dst_q[8*(5-idx_q) +: 8];
        end else if (idx_q < 5'd12) begin
            cur = src_q[8*(11-idx_q) +: 8];
        end else begin
            cur = {3'h5, idx_q};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            idx_q <= 5'h00;
            hold_q <= 8'h00;
        end else if (!busy_q && go) begin
            busy_q <= 1'b1;
            idx_q <= 5'h00;
            dst_q <= dst;
            src_q <= src;
            fl_q <= fl;
            tot_q <= 5'd11 + {1'b0, extra};
        end else if (busy_q) begin
            idx_q <= idx_q + 5'd1;
            busy_q <= (idx_q != tot_q);
            hold_q <= cur;
        end
    end

    // idle lines show the inverse of the last value
    assign rx_valid = busy_q;
    assign rx_data = busy_q ? cur : ~hold_q;
    assign rx_last = busy_q && (idx_q == tot_q);
    assign cls = rx_last ? fl_q : ~fl_q;
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import rff_pkg::*;
    logic clk = 0, rst_n = 0, go = 0, ce = 1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, rd_v;
    logic reg_wr = 0, reg_rd = 0;
    logic [15:0] reg_rdata;
    logic [47:0] dst = 48'h0, src = 48'h0;
    logic [47:0] tab [4];
    logic [3:0] extra = 4'h0;
    logic [6:0] fl = 7'h00, cls;
    logic rx_valid, rx_last, acc, drp, a, d;
    logic [7:0] rx_data;
    logic rx_running, tx_gen;
    logic [26:0] rows [20];
    int error_cnt = 0, check_count = 0;

    always #2.5 clk = ~clk;

    rff_filter_top dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .pkt_udp(cls[6]),
        .pkt_udp_lite(cls[5]), .pkt_icmp(cls[4]), .pkt_frag(cls[3]),
        .udp_csum_zero(cls[2]), .udp_lite_csum_ok(cls[1]),
        .icmp_csum_ok(cls[0]), .frm_accept(acc), .frm_drop(drp),
        .rx_running(rx_running), .tx_udp_lite_gen_en(tx_gen));

    rff_phy_model phy_u (.clk(clk), .rst_n(rst_n), .go(go), .dst(dst),
        .src(src), .extra(extra), .fl(fl), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .cls(cls));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string msg);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, output logic [15:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic send(input logic [47:0] da, input logic [47:0] sa,
                        input logic [3:0] ex, input logic [6:0] f);
        @(posedge clk);
        go <= 1'b1;
        dst <= da;
        src <= sa;
        extra <= ex;
        fl <= f;
        @(posedge clk);
        go <= 1'b0;
    endtask

    // result pulse one cycle after the last byte
    task automatic wait_res(output logic ra, output logic rdr);
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            #1;
            if (rx_last === 1'b1) break;
        end
        @(posedge clk);
        #1;
        ra = acc;
        rdr = drp;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////
    // rows: ctrl1 low, ctrl2 low, dst pick, src is station, class, accept
    // dst pick: 0 broadcast, 1 multicast, 2 station, 3 other unicast
    initial begin
        tab = '{48'hffff_ffff_ffff, 48'h0100_5e00_0001,
                48'h0211_2233_4455, 48'h02aa_bbcc_ddee};
        rows[0] = {8'h81, 8'h04, 2'd0, 1'b0, 7'h00, 1'b1};
        rows[1] = {8'h01, 8'h04, 2'd0, 1'b0, 7'h00, 1'b0};
        rows[2] = {8'h41, 8'h04, 2'd0, 1'b0, 7'h00, 1'b1};
        rows[3] = {8'h41, 8'h04, 2'd1, 1'b0, 7'h00, 1'b1};
        rows[4] = {8'h21, 8'h04, 2'd2, 1'b0, 7'h00, 1'b1};
        rows[5] = {8'h21, 8'h04, 2'd3, 1'b0, 7'h00, 1'b0};
        rows[6] = {8'h11, 8'h04, 2'd3, 1'b0, 7'h00, 1'b1};
        rows[7] = {8'h23, 8'h04, 2'd2, 1'b0, 7'h00, 1'b0};
        rows[8] = {8'h23, 8'h04, 2'd3, 1'b0, 7'h00, 1'b1};
        rows[9] = {8'h11, 8'h00, 2'd3, 1'b0, 7'h44, 1'b0};
        rows[10] = {8'h11, 8'h08, 2'd3, 1'b0, 7'h44, 1'b1};
        rows[11] = {8'h11, 8'h10, 2'd3, 1'b0, 7'h4c, 1'b1};
        rows[12] = {8'h11, 8'h00, 2'd3, 1'b0, 7'h4c, 1'b0};
        rows[13] = {8'h11, 8'h04, 2'd3, 1'b0, 7'h60, 1'b0};
        rows[14] = {8'h11, 8'h00, 2'd3, 1'b0, 7'h60, 1'b1};
        rows[15] = {8'h11, 8'h02, 2'd3, 1'b0, 7'h10, 1'b0};
        rows[16] = {8'h11, 8'h02, 2'd3, 1'b0, 7'h18, 1'b1};
        rows[17] = {8'h11, 8'h01, 2'd3, 1'b1, 7'h00, 1'b0};
        rows[18] = {8'h11, 8'h00, 2'd3, 1'b1, 7'h00, 1'b1};
        rows[19] = {8'h1d, 8'h00, 2'd3, 1'b0, 7'h00, 1'b1};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // reset values and read-only bits
        rd(RFF_OFF_CTRL1, rd_v);
        check(rd_v, 16'h0000, "ctrl1 reset");
        rd(RFF_OFF_CTRL2, rd_v);
        check(rd_v, 16'h0004, "ctrl2 reset");
        check({15'h0, tx_gen}, 16'h0001, "gen reset");
        check({15'h0, rx_running}, 16'h0000, "stopped");
        wr(RFF_OFF_CTRL2, 16'hffff);
        rd(RFF_OFF_CTRL2, rd_v);
        check(rd_v, 16'h001f, "ctrl2 upper");
        wr(RFF_OFF_CTRL2, 16'h0000);
        rd(8'h7e, rd_v);
        check(rd_v, 16'h0000, "unmapped");
        check({15'h0, tx_gen}, 16'h0000, "gen off");
        $display("test registers done");
        // stopped receiver ignores frames
        send(tab[0], tab[3], 4'h0, 7'h00);
        wait_res(a, d);
        check({14'h0, a, d}, 16'h0000, "stopped frame");
        wr(RFF_OFF_SA_HIGH, 16'h0211);
        wr(RFF_OFF_SA_MID, 16'h2233);
        wr(RFF_OFF_SA_LOW, 16'h4455);
        $display("test stopped done");
        // one payload byte: header-only frames are dropped
        foreach (rows[i]) begin
            wr(RFF_OFF_CTRL1, {8'h00, rows[i][26:19]});
            wr(RFF_OFF_CTRL2, {8'h00, rows[i][18:11]});
            check({15'h0, rx_running}, 16'h0001, "running");
            send(tab[rows[i][10:9]], rows[i][8] ? tab[2] : tab[3], 4'h1,
                 rows[i][7:1]);
            wait_res(a, d);
            check({14'h0, a, d}, {14'h0, rows[i][0], ~rows[i][0]},
                  "filter row");
        end
        $display("test filter table done");
        // readback, then clock enable low freezes the registers
        rd(RFF_OFF_CTRL1, rd_v);
        check(rd_v, 16'h001d, "reserved bits held");
        rd(RFF_OFF_STATUS, rd_v);
        check(rd_v, 16'h0001, "status running");
        rd(RFF_OFF_SA_HIGH, rd_v);
        check(rd_v, 16'h0211, "station high");
        @(posedge clk);
        ce <= 1'b0;
        wr(RFF_OFF_CTRL1, 16'h0000);
        @(posedge clk);
        ce <= 1'b1;
        rd(RFF_OFF_CTRL1, rd_v);
        check(rd_v, 16'h001d, "frozen write");
        check({15'h0, rx_running}, 16'h0001, "frozen run");
        $display("test clock enable done");
        // run cleared mid-frame: frame completes, then stop
        send(tab[3], tab[3], 4'h8, 7'h00);
        wr(RFF_OFF_CTRL1, 16'h0010);
        wait_res(a, d);
        check({14'h0, a, d}, 16'h0002, "finish frame");
        repeat (2) @(posedge clk);
        #1;
        check({15'h0, rx_running}, 16'h0000, "stop after");
        send(tab[3], tab[3], 4'h0, 7'h00);
        wait_res(a, d);
        check({14'h0, a, d}, 16'h0000, "ignored");
        $display("test graceful stop done");
        // reset in mid-frame: registers and outputs back to reset
        wr(RFF_OFF_CTRL1, 16'h0011);
        send(tab[3], tab[3], 4'h8, 7'h00);
        repeat (4) @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check({14'h0, acc, drp}, 16'h0000, "no pulse after reset");
        check({15'h0, rx_running}, 16'h0000, "reset stopped");
        check({15'h0, tx_gen}, 16'h0001, "reset gen");
        rd(RFF_OFF_CTRL1, rd_v);
        check(rd_v, 16'h0000, "ctrl1 after reset");
        rd(RFF_OFF_CTRL2, rd_v);
        check(rd_v, 16'h0004, "ctrl2 after reset");
        repeat (2) @(posedge clk);
        #1;
        check({14'h0, acc, drp}, 16'h0000, "quiet after reset");
        $display("test mid reset done");
        report_and_stop();
    end
endmodule
